// [rtl/asa_top.v]
// alarm sticky aggregator with axi4-lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "asa_defines.vh"
module asa_top (
   input  wire                                   aclk,
   input  wire                                   aresetn,
   input  wire [7:0]                             s_awaddr,
   input  wire                                   s_awvalid,
   output reg                                    s_awready,
   input  wire [31:0]                            s_wdata,
   input  wire [3:0]                             s_wstrb,
   input  wire                                   s_wvalid,
   output reg                                    s_wready,
   output reg  [1:0]                             s_bresp,
   output reg                                    s_bvalid,
   input  wire                                   s_bready,
   input  wire [7:0]                             s_araddr,
   input  wire                                   s_arvalid,
   output reg                                    s_arready,
   output reg  [31:0]                            s_rdata,
   output reg  [1:0]                             s_rresp,
   output reg                                    s_rvalid,
   input  wire                                   s_rready,
   input  wire [`ASA_NUM_REF-1:0]                ref_foff_cond,
   input  wire [`ASA_NUM_REF-1:0]                ref_los_cond,
   input  wire [`ASA_NUM_REF-1:0]                ref_act_cond,
   input  wire [`ASA_NUM_DPLL*`ASA_STATE_W-1:0]  dpll_state,
   input  wire                                   apll_locked,
   output reg  [`ASA_NUM_GPIO-1:0]               gpio_out,
   output reg  [`ASA_NUM_GPIO-1:0]               gpio_oe
);
   reg                                   glob_en;
   reg  [`ASA_NUM_ALARM-1:0]             alert_en;
   reg  [7:0]                            gpio_cfg [0:`ASA_NUM_GPIO-1];
   reg  [`ASA_NUM_BLK-1:0]               blk_sticky;
   reg  [`ASA_NUM_ALARM-1:0]             clr_pulse;
   reg  [`ASA_NUM_BLK-1:0]               blk_clr_pulse;
   reg                                   alert_q;
   wire [`ASA_NUM_ALARM-1:0]             live;
   wire [`ASA_NUM_ALARM-1:0]             sticky;
   wire [`ASA_NUM_ALARM-1:0]             contrib;
   wire [`ASA_NUM_BLK-1:0]               blk_set;
   wire                                  alert_raw;

   // write channel holding state
   reg                                   aw_full;
   reg                                   w_full;
   reg  [7:0]                            aw_addr;
   reg  [31:0]                           wdata;
   reg  [3:0]                            wstrb;
   reg                                   next_aw_full;
   reg                                   next_w_full;
   reg                                   next_bvalid;
   reg                                   next_rvalid;
   reg  [31:0]                           rd_mux;
   reg                                   rd_hit;
   reg                                   wr_hit;
   wire                                  wr_go;
   wire [31:0]                           wmask;
   wire [31:0]                           wbits;
   integer                               gi;
   integer                               ri;
   integer                               oi;

   assign wr_go = aw_full & w_full & ~s_bvalid;
   assign wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
   assign wbits = wdata & wmask;

   // live alarm derivation
   genvar r;
   generate
      for (r = 0; r < `ASA_NUM_REF; r = r + 1) begin : g_ref
         assign live[`ASA_IDX_FOFF + r] = ref_foff_cond[r];
         assign live[`ASA_IDX_LOS + r]  = ref_los_cond[r];
         assign live[`ASA_IDX_ACT + r]  = ref_act_cond[r];
      end
      for (r = 0; r < `ASA_NUM_DPLL; r = r + 1) begin : g_dpll
         wire [`ASA_STATE_W-1:0] st;
         assign st = dpll_state[r*`ASA_STATE_W +: `ASA_STATE_W];
         // entering or leaving a state is a live change, so stickies follow transitions
         assign live[`ASA_IDX_HOLD + r] = (st == `ASA_ST_HOLDOVER);
         assign live[`ASA_IDX_LOCK + r] = (st == `ASA_ST_LOCKED) & apll_locked;
      end
   endgenerate

   // one independent flag per alarm
   genvar a;
   generate
      for (a = 0; a < `ASA_NUM_ALARM; a = a + 1) begin : g_alarm
         localparam integer BLK = (a < `ASA_IDX_HOLD) ? (a % `ASA_NUM_REF)
                                  : (`ASA_NUM_REF + ((a - `ASA_IDX_HOLD) % `ASA_NUM_DPLL));
         asa_sticky_cell u_cell (
            .aclk    (aclk),
            .aresetn (aresetn),
            .live    (live[a]),
            .enable  (glob_en),
            .clr     (clr_pulse[a]),
            .sticky  (sticky[a])
         );
         // an enabled source stays up while either its own or its block flag is set
         assign contrib[a] = alert_en[a] & (sticky[a] | blk_sticky[BLK]);
      end
   endgenerate

   // block flags are fed by any set alarm flag of the block
   genvar b;
   generate
      for (b = 0; b < `ASA_NUM_BLK; b = b + 1) begin : g_blk
         if (b < `ASA_NUM_REF) begin : g_rb
            assign blk_set[b] = sticky[`ASA_IDX_FOFF + b] | sticky[`ASA_IDX_LOS + b]
                              | sticky[`ASA_IDX_ACT + b];
         end else begin : g_db
            assign blk_set[b] = sticky[`ASA_IDX_HOLD + b - `ASA_NUM_REF]
                              | sticky[`ASA_IDX_LOCK + b - `ASA_NUM_REF];
         end
         always @(posedge aclk) begin
            if (!aresetn) begin
               blk_sticky[b] <= 1'b0;
            end else if (blk_set[b]) begin
               // leftover alarm flags re-raise the block flag, hence clear them first
               blk_sticky[b] <= 1'b1;
            end else if (blk_clr_pulse[b]) begin
               blk_sticky[b] <= 1'b0;
            end
         end
      end
   endgenerate

   assign alert_raw = |contrib;

   // write channel: address and data taken in either order
   always @* begin
      next_aw_full = aw_full;
      next_w_full  = w_full;
      next_bvalid  = s_bvalid;
      if (s_bvalid && s_bready) begin
         next_bvalid = 1'b0;
      end
      if (s_awvalid && s_awready) begin
         next_aw_full = 1'b1;
      end
      if (s_wvalid && s_wready) begin
         next_w_full = 1'b1;
      end
      if (wr_go) begin
         next_aw_full = 1'b0;
         next_w_full  = 1'b0;
         next_bvalid  = 1'b1;
      end
   end

   always @* begin
      wr_hit = 1'b1;
      case (aw_addr)
         `ASA_REG_CTRL, `ASA_REG_STICKY_CLR, `ASA_REG_ALERT_EN, `ASA_REG_BLK_CLR,
         `ASA_REG_LIVE, `ASA_REG_STICKY, `ASA_REG_BLK_STICKY, `ASA_REG_STATE,
         `ASA_REG_STATUS: wr_hit = 1'b1;
         default: wr_hit = (aw_addr >= `ASA_REG_GPIO0) && (aw_addr <= `ASA_REG_GPIO3)
                           && (aw_addr[1:0] == 2'h0);
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full   <= 1'b0;
         w_full    <= 1'b0;
         aw_addr   <= 8'h00;
         wdata     <= 32'h00000000;
         wstrb     <= 4'h0;
         s_awready <= 1'b0;
         s_wready  <= 1'b0;
         s_bvalid  <= 1'b0;
         s_bresp   <= `ASA_RESP_OKAY;
      end else begin
         aw_full   <= next_aw_full;
         w_full    <= next_w_full;
         s_bvalid  <= next_bvalid;
         s_awready <= ~next_aw_full & ~next_bvalid;
         s_wready  <= ~next_w_full & ~next_bvalid;
         if (s_awvalid && s_awready) begin
            aw_addr <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            wdata <= s_wdata;
            wstrb <= s_wstrb;
         end
         if (wr_go) begin
            s_bresp <= wr_hit ? `ASA_RESP_OKAY : `ASA_RESP_SLVERR;
         end
      end
   end

   // register writes; clears are one-cycle pulses of the written ones
   always @(posedge aclk) begin
      if (!aresetn) begin
         glob_en       <= `ASA_RST_CTRL;
         alert_en      <= `ASA_RST_ALERT_EN;
         clr_pulse     <= {`ASA_NUM_ALARM{1'b0}};
         blk_clr_pulse <= {`ASA_NUM_BLK{1'b0}};
         for (gi = 0; gi < `ASA_NUM_GPIO; gi = gi + 1) begin
            gpio_cfg[gi] <= `ASA_RST_GCFG;
         end
      end else begin
         clr_pulse     <= {`ASA_NUM_ALARM{1'b0}};
         blk_clr_pulse <= {`ASA_NUM_BLK{1'b0}};
         if (wr_go) begin
            case (aw_addr)
               `ASA_REG_CTRL: begin
                  if (wstrb[0]) begin
                     glob_en <= wdata[`ASA_CTRL_GEN_BIT];
                  end
               end
               `ASA_REG_STICKY_CLR: begin
                  clr_pulse <= wbits[`ASA_NUM_ALARM-1:0];
               end
               `ASA_REG_BLK_CLR: begin
                  blk_clr_pulse <= wbits[`ASA_NUM_BLK-1:0];
               end
               `ASA_REG_ALERT_EN: begin
                  alert_en <= (alert_en & ~wmask[`ASA_NUM_ALARM-1:0])
                            | wbits[`ASA_NUM_ALARM-1:0];
               end
               default: begin
                  for (gi = 0; gi < `ASA_NUM_GPIO; gi = gi + 1) begin
                     if (wstrb[0] && (aw_addr == (`ASA_REG_GPIO0 + 8'h04 * gi[7:0]))) begin
                        gpio_cfg[gi] <= wdata[7:0];
                     end
                  end
               end
            endcase
         end
      end
   end

   // read channel; data sampled at the address handshake
   always @* begin
      rd_mux = 32'h00000000;
      rd_hit = 1'b1;
      case (s_araddr)
         `ASA_REG_CTRL:       rd_mux[`ASA_CTRL_GEN_BIT] = glob_en;
         `ASA_REG_LIVE:       rd_mux[`ASA_NUM_ALARM-1:0] = live;
         `ASA_REG_STICKY:     rd_mux[`ASA_NUM_ALARM-1:0] = sticky;
         `ASA_REG_STICKY_CLR: rd_mux = 32'h00000000;
         `ASA_REG_ALERT_EN:   rd_mux[`ASA_NUM_ALARM-1:0] = alert_en;
         `ASA_REG_BLK_STICKY: rd_mux[`ASA_NUM_BLK-1:0] = blk_sticky;
         `ASA_REG_BLK_CLR:    rd_mux = 32'h00000000;
         `ASA_REG_STATE:      rd_mux[`ASA_NUM_DPLL*`ASA_STATE_W-1:0] = dpll_state;
         `ASA_REG_STATUS:     rd_mux[0] = alert_q;
         default: begin
            rd_hit = 1'b0;
            for (ri = 0; ri < `ASA_NUM_GPIO; ri = ri + 1) begin
               if (s_araddr == (`ASA_REG_GPIO0 + 8'h04 * ri[7:0])) begin
                  rd_mux[7:0] = gpio_cfg[ri];
                  rd_hit      = 1'b1;
               end
            end
         end
      endcase
   end

   always @* begin
      next_rvalid = s_rvalid;
      if (s_rvalid && s_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_arvalid && s_arready) begin
         next_rvalid = 1'b1;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_arready <= 1'b0;
         s_rvalid  <= 1'b0;
         s_rdata   <= 32'h00000000;
         s_rresp   <= `ASA_RESP_OKAY;
      end else begin
         s_rvalid  <= next_rvalid;
         s_arready <= ~next_rvalid;
         if (s_arvalid && s_arready) begin
            s_rdata <= rd_mux;
            s_rresp <= rd_hit ? `ASA_RESP_OKAY : `ASA_RESP_SLVERR;
         end
      end
   end

   // gpio drive: one cycle after a flag change, far inside the allowed lag
   always @(posedge aclk) begin
      if (!aresetn) begin
         alert_q  <= 1'b0;
         gpio_out <= {`ASA_NUM_GPIO{1'b0}};
         gpio_oe  <= {`ASA_NUM_GPIO{1'b0}};
      end else begin
         alert_q <= alert_raw;
         for (oi = 0; oi < `ASA_NUM_GPIO; oi = oi + 1) begin
            gpio_oe[oi] <= (gpio_cfg[oi][`ASA_GCFG_MODE_MSB:`ASA_GCFG_MODE_LSB] != `ASA_MODE_OFF);
            case (gpio_cfg[oi][`ASA_GCFG_MODE_MSB:`ASA_GCFG_MODE_LSB])
               `ASA_MODE_LIVE:   gpio_out[oi] <= gpio_cfg[oi][`ASA_GCFG_INV_BIT]
                                               ^ live[gpio_cfg[oi][`ASA_GCFG_SEL_MSB:`ASA_GCFG_SEL_LSB]];
               `ASA_MODE_STICKY: gpio_out[oi] <= gpio_cfg[oi][`ASA_GCFG_INV_BIT]
                                               ^ sticky[gpio_cfg[oi][`ASA_GCFG_SEL_MSB:`ASA_GCFG_SEL_LSB]];
               `ASA_MODE_ALERT:  gpio_out[oi] <= gpio_cfg[oi][`ASA_GCFG_INV_BIT] ^ alert_raw;
               default:          gpio_out[oi] <= 1'b0;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// [rtl/asa_defines.vh]
// constants for the alarm sticky aggregator: offsets, fields, reset values
`ifndef ASA_DEFINES_VH
`define ASA_DEFINES_VH

`define ASA_NUM_REF        4
`define ASA_NUM_DPLL       5
`define ASA_NUM_ALARM      22
`define ASA_NUM_BLK        9
`define ASA_NUM_GPIO       4
`define ASA_STATE_W        3

// alarm index bases
`define ASA_IDX_FOFF       0
`define ASA_IDX_LOS        4
`define ASA_IDX_ACT        8
`define ASA_IDX_HOLD       12
`define ASA_IDX_LOCK       17

// loop state codes
`define ASA_ST_LOCKED      3'h3
`define ASA_ST_HOLDOVER    3'h4

// register byte offsets
`define ASA_REG_CTRL       8'h00
`define ASA_REG_LIVE       8'h04
`define ASA_REG_STICKY     8'h08
`define ASA_REG_STICKY_CLR 8'h0C
`define ASA_REG_ALERT_EN   8'h10
`define ASA_REG_BLK_STICKY 8'h14
`define ASA_REG_BLK_CLR    8'h18
`define ASA_REG_STATE      8'h1C
`define ASA_REG_GPIO0      8'h20
`define ASA_REG_GPIO3      8'h2C
`define ASA_REG_STATUS     8'h30

// control and gpio config fields
`define ASA_CTRL_GEN_BIT   0
`define ASA_GCFG_SEL_LSB   0
`define ASA_GCFG_SEL_MSB   4
`define ASA_GCFG_MODE_LSB  5
`define ASA_GCFG_MODE_MSB  6
`define ASA_GCFG_INV_BIT   7

`define ASA_MODE_OFF       2'h0
`define ASA_MODE_LIVE      2'h1
`define ASA_MODE_STICKY    2'h2
`define ASA_MODE_ALERT     2'h3

// reset values
`define ASA_RST_CTRL       1'h0
`define ASA_RST_ALERT_EN   22'h000000
`define ASA_RST_GCFG       8'h00

`define ASA_RESP_OKAY      2'h0
`define ASA_RESP_SLVERR    2'h2

`endif

// [rtl/asa_sticky_cell.v]
// one alarm flag with change detection and clear
`timescale 1ns/10ps
`default_nettype none
module asa_sticky_cell (
   input  wire aclk,
   input  wire aresetn,
   input  wire live,
   input  wire enable,
   input  wire clr,
   output reg  sticky
);
   reg prev;

   always @(posedge aclk) begin
      if (!aresetn) begin
         prev   <= 1'b0;
         sticky <= 1'b0;
      end else begin
         prev <= live;
         if (enable && (live != prev)) begin
            sticky <= 1'b1;
         end else if (clr) begin
            sticky <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// [verif/asa_top_chk.sv]
// bus and pin assertions for the alarm sticky aggregator
`timescale 1ns/10ps
`default_nettype none
module asa_top_chk (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [7:0]  s_awaddr,
   input wire logic        s_awvalid,
   input wire logic        s_awready,
   input wire logic        s_wvalid,
   input wire logic        s_wready,
   input wire logic [1:0]  s_bresp,
   input wire logic        s_bvalid,
   input wire logic        s_bready,
   input wire logic [7:0]  s_araddr,
   input wire logic        s_arvalid,
   input wire logic        s_arready,
   input wire logic [31:0] s_rdata,
   input wire logic [1:0]  s_rresp,
   input wire logic        s_rvalid,
   input wire logic        s_rready,
   input wire logic [3:0]  gpio_out,
   input wire logic [3:0]  gpio_oe
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wr_answer_a: assert property (s_awvalid && s_awready && s_wvalid && s_wready |=> ##1
      s_bvalid && s_bresp == ((($past(s_awaddr, 2) > 8'h30)
         || ($past(s_awaddr, 2) & 8'h03) != 8'h00) ? 2'h2 : 2'h0)) else $error("bad write answer");
   rd_answer_a: assert property (s_arvalid && s_arready |=> s_rvalid &&
      ((($past(s_araddr) > 8'h30) || ($past(s_araddr) & 8'h03) != 8'h00)
         ? (s_rresp == 2'h2 && s_rdata == 32'h0) : s_rresp == 2'h0))
      else $error("bad read answer");
   b_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
      else $error("write answer dropped");
   r_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
      else $error("read answer dropped");
   ar_block_a: assert property (s_rvalid |-> !s_arready) else $error("read taken while busy");
   wr_reopen_a: assert property (s_bvalid && s_bready |=> !s_bvalid ##1 (s_awready && s_wready))
      else $error("write channel not reopened");
   rd_reopen_a: assert property (s_rvalid && s_rready |=> !s_rvalid ##1 s_arready)
      else $error("read channel not reopened");
   rst_quiet_a: assert property (disable iff (1'b0) !aresetn |=>
      gpio_out == 4'h0 && gpio_oe == 4'h0 && !s_bvalid && !s_rvalid) else $error("outputs active after reset");
endmodule
bind asa_top asa_top_chk u_asa_top_chk (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
   .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready),
   .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
   .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
   .s_rvalid(s_rvalid), .s_rready(s_rready), .gpio_out(gpio_out), .gpio_oe(gpio_oe));
`default_nettype wire

// [verif/asa_host.sv]
// host side: register bus master that reads and clears alarm flags
`timescale 1ns/10ps
`default_nettype none
`include "asa_defines.vh"
module asa_host (
   input  wire logic        aclk,
   output var  logic [7:0]  s_awaddr,
   output var  logic        s_awvalid,
   input  wire logic        s_awready,
   output var  logic [31:0] s_wdata,
   output var  logic [3:0]  s_wstrb,
   output var  logic        s_wvalid,
   input  wire logic        s_wready,
   input  wire logic [1:0]  s_bresp,
   input  wire logic        s_bvalid,
   output var  logic        s_bready,
   output var  logic [7:0]  s_araddr,
   output var  logic        s_arvalid,
   input  wire logic        s_arready,
   input  wire logic [31:0] s_rdata,
   input  wire logic [1:0]  s_rresp,
   input  wire logic        s_rvalid,
   output var  logic        s_rready
);
   initial {s_awaddr, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready, s_araddr, s_arvalid, s_rready} = '0;
   // released payload is inverted so a stale value is never mistaken for a live one
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      {s_awaddr, s_wdata, s_wstrb, s_awvalid, s_wvalid} <= {a, d, 4'hF, 2'b11};
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (s_awvalid && s_awready) begin
            aw_done = 1'b1;
            {s_awvalid, s_awaddr} <= {1'b0, ~a};
         end
         if (s_wvalid && s_wready) begin
            w_done = 1'b1;
            {s_wvalid, s_wdata} <= {1'b0, ~d};
         end
      end
      s_bready <= 1'b1;
      do @(posedge aclk); while (!s_bvalid);
      r = s_bresp;
      s_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      {s_araddr, s_arvalid} <= {a, 1'b1};
      do @(posedge aclk); while (!s_arready);
      {s_araddr, s_arvalid, s_rready} <= {~a, 2'b01};
      do @(posedge aclk); while (!s_rvalid);
      d = s_rdata;
      r = s_rresp;
      s_rready <= 1'b0;
   endtask
   // alarm flags first, else a leftover flag sets its block flag again
   task automatic service(input logic [21:0] alarms, input logic [8:0] blocks);
      logic [1:0] r;
      wr(`ASA_REG_STICKY_CLR, {10'h0, alarms}, r);
      wr(`ASA_REG_BLK_CLR, {23'h0, blocks}, r);
   endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the alarm sticky aggregator
`timescale 1ns/10ps
`default_nettype none
`include "asa_defines.vh"
module testbench;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [11:0] refs = 12'h000;
   logic [14:0] dpll_state = 15'h0000;
   logic        apll_locked = 1'b0;
   wire  [7:0]  s_awaddr, s_araddr;
   wire  [31:0] s_wdata, s_rdata;
   wire  [3:0]  s_wstrb, gpio_out, gpio_oe;
   wire  [1:0]  s_bresp, s_rresp;
   wire         s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   wire         s_arvalid, s_arready, s_rvalid, s_rready;
   integer      seed = 6;
   integer      bad_count = 0;
   integer      n_compared = 0;
   logic [21:0] stk, en, m;
   logic [8:0]  blk;
   logic        gen, cfg;
   logic [31:0] d;
   logic [1:0]  r;
   always #2.5 aclk = ~aclk;
   asa_top u_asa_top (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
      .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
      .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
      .ref_foff_cond(refs[3:0]), .ref_los_cond(refs[7:4]), .ref_act_cond(refs[11:8]),
      .dpll_state(dpll_state), .apll_locked(apll_locked), .gpio_out(gpio_out), .gpio_oe(gpio_oe));
   asa_host u_asa_host (.aclk(aclk), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
      .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
      .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared = n_compared + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
      u_asa_host.rd(a, d, r);
      chk($sformatf("register %h", a), exp, d);
   endtask
   function automatic logic [21:0] live_of();
      logic [21:0] v;
      v = {10'h000, refs};
      for (int k = 0; k < 5; k++) begin
         v[12+k] = dpll_state[3*k+:3] == `ASA_ST_HOLDOVER;
         v[17+k] = dpll_state[3*k+:3] == `ASA_ST_LOCKED && apll_locked;
      end
      return v;
   endfunction
   function automatic int blk_of(input int i);
      return (i < 12) ? i % 4 : (i < 17) ? i - 8 : i - 13;
   endfunction
   function automatic logic alert_of();
      logic a;
      a = 1'b0;
      for (int i = 0; i < 22; i++) a = a | (en[i] & (stk[i] | blk[blk_of(i)]));
      return a;
   endfunction
   task automatic apply(input logic [11:0] rv, input logic [14:0] st, input logic al);
      logic [21:0] old;
      old = live_of();
      @(posedge aclk);
      {refs, dpll_state, apll_locked} <= {rv, st, al};
      repeat (4) @(posedge aclk);
      if (gen) stk = stk | (old ^ live_of());
      for (int i = 0; i < 22; i++) if (stk[i]) blk[blk_of(i)] = 1'b1;
   endtask
   task automatic check_all();
      logic [21:0] lv;
      lv = live_of();
      chk_reg(`ASA_REG_LIVE, {10'h0, lv});
      chk_reg(`ASA_REG_STICKY, {10'h0, stk});
      chk_reg(`ASA_REG_BLK_STICKY, {23'h0, blk});
      chk_reg(`ASA_REG_STATE, {17'h0, dpll_state});
      chk_reg(`ASA_REG_STATUS, {31'h0, alert_of()});
      // pins in off mode drive low until configured
      chk("alert pin", {31'h0, cfg & alert_of()}, {31'h0, gpio_out[0]});
      chk("inverted alert pin", {31'h0, cfg & ~alert_of()}, {31'h0, gpio_out[3]});
      chk("live alarm pin", {31'h0, cfg & lv[18]}, {31'h0, gpio_out[2]});
      if (stk[13] || !blk[5]) chk("sticky alarm pin", {31'h0, cfg & stk[13]}, {31'h0, gpio_out[1]});
   endtask
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #(90000 * 5);
      bad_count = bad_count + 1;
      close_out();
   end
   initial begin
      {gen, cfg, stk, blk, en} = '0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("pins after reset", 32'h0, {24'h0, gpio_oe, gpio_out});
      chk_reg(`ASA_REG_CTRL, 32'h0);
      chk_reg(`ASA_REG_ALERT_EN, 32'h0);
      check_all();
      apply(12'h010, 15'h0000, 1'b0);
      check_all();
      u_asa_host.rd(8'h40, d, r);
      chk("unmapped read response", 32'h2, {30'h0, r});
      u_asa_host.wr(8'h44, 32'hFFFFFFFF, r);
      chk("unmapped write response", 32'h2, {30'h0, r});
      u_asa_host.wr(`ASA_REG_CTRL, 32'h1, r);
      gen = 1'b1;
      // alert, sticky of alarm 13, live of alarm 18, inverted alert
      u_asa_host.wr(`ASA_REG_GPIO0, 32'h60, r);
      u_asa_host.wr(`ASA_REG_GPIO0 + 8'h04, 32'h4D, r);
      u_asa_host.wr(`ASA_REG_GPIO0 + 8'h08, 32'h32, r);
      u_asa_host.wr(`ASA_REG_GPIO3, 32'hE0, r);
      cfg = 1'b1;
      for (int rnd = 0; rnd < 2; rnd++) begin
         en = (rnd == 0) ? 22'h3FFFFF : 22'($random(seed));
         u_asa_host.wr(`ASA_REG_ALERT_EN, {10'h0, en}, r);
         chk("pin enables", 32'hF, {28'h0, gpio_oe});
         check_all();
         for (int n = 0; n < 10; n++) begin
            apply(12'($random(seed)), 15'($random(seed)), 1'($random(seed)));
            check_all();
         end
         // clear pulse and a fresh change of alarm 0 meet in one cycle
         fork
            u_asa_host.wr(`ASA_REG_STICKY_CLR, 32'h1, r);
            begin
               repeat (3) @(posedge aclk);
               refs[0] <= ~refs[0];
            end
         join
         stk[0] = 1'b1;
         blk[0] = 1'b1;
         check_all();
         m = stk & (~stk + 22'h1);
         u_asa_host.wr(`ASA_REG_STICKY_CLR, {10'h0, m}, r);
         stk = stk & ~m;
         check_all();
         u_asa_host.wr(`ASA_REG_STICKY_CLR, 32'h3FFFFF, r);
         stk = '0;
         check_all();
         u_asa_host.service(22'h3FFFFF, 9'h1FF);
         blk = '0;
         // polled, not edge-triggered: the pin may trail the clears
         for (int w = 0; w < 40000 && gpio_out[0] !== 1'b0; w++) @(posedge aclk);
         chk("alert after clears", 32'h0, {31'h0, gpio_out[0]});
         check_all();
      end
      close_out();
   end
endmodule
`default_nettype wire
